// file: compact_stack_multi_ldst_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "stack_ldst_map.vh"

module compact_stack_multi_ldst_decode (
	// clock and reset
	input  wire        mclk,
	input  wire        reset_n,
	// instruction issue
	input  wire        instr_valid,
	input  wire [15:0] instr,
	input  wire [31:0] instr_addr,
	output wire        instr_ready,
	output wire        instr_done,
	output wire        instr_unsupported,
	// program counter redirect
	output wire        branch_valid,
	output wire [31:0] branch_target,
	// condition flags owned by the other formats
	input  wire        flags_wr,
	input  wire [3:0]  flags_wdata,
	output wire [3:0]  flags,
	// data bus
	output wire        mem_req,
	output wire        mem_write,
	output wire [31:0] mem_addr,
	output wire [31:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	// register view
	input  wire [3:0]  dbg_sel,
	output wire [31:0] dbg_data
);

	localparam S_IDLE   = 4'h1;
	localparam S_MEM    = 4'h2;
	localparam S_FIN    = 4'h4;
	localparam S_REFILL = 4'h8;

	// ---------------------------------------------------------------
	// architectural state
	// ---------------------------------------------------------------
	reg  [31:0] low_reg [0:7];
	reg  [31:0] stack_pointer_reg;
	reg  [31:0] link_register_reg;
	reg  [3:0]  status_flags_register_reg;

	// ---------------------------------------------------------------
	// sequencing state
	// ---------------------------------------------------------------
	reg  [3:0]             state_reg;
	reg  [`MASK_W-1:0]     mask_reg;
	reg  [`IDX_W-1:0]      idx_reg;
	reg                    load_reg;
	reg                    wb_en_reg;
	reg                    wb_sp_reg;
	reg  [2:0]             wb_idx_reg;
	reg  [31:0]            wb_val_reg;
	reg                    pc_loaded_reg;
	reg  [1:0]             refill_cnt_reg;
	reg                    mem_req_reg;
	reg                    mem_write_reg;
	reg  [31:0]            mem_addr_reg;
	reg  [31:0]            mem_wdata_reg;
	reg                    ready_reg;
	reg                    done_reg;
	reg                    unsup_reg;
	reg                    branch_reg;
	reg  [31:0]            target_reg;
	reg  [31:0]            dbg_reg;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire [3:0]  op4      = instr[`OP4_HI:`OP4_LO];
	wire        lbit     = instr[`LBIT];
	wire [2:0]  rd       = instr[`RD_HI:`RD_LO];
	wire [7:0]  scaled_word_offset_field = instr[`IMM8_HI:`IMM8_LO];
	wire [6:0]  stack_adjust_field       = instr[`ADJ_HI:`ADJ_LO];
	wire        is_sp_ldst = (op4 == `OP_SP_LDST);
	wire        is_addr    = (op4 == `OP_ADDR_GEN);
	wire        is_adj     = (instr[`OP4_HI:`OP8_LO] == `OP_SP_ADJ);
	wire        is_pp      = (op4 == `OP_PUSH_POP) &&
	                         (instr[`PP_SEL_HI:`PP_SEL_LO] == `PP_SEL_CODE);
	wire        is_multi   = (op4 == `OP_MULTI);
	wire        take       = instr_valid && ready_reg;

	wire [31:0] word_off   = {22'h0, scaled_word_offset_field, {`WORD_SHIFT{1'b0}}};
	wire [31:0] adj_mag    = {23'h0, stack_adjust_field, {`WORD_SHIFT{1'b0}}};
	wire [31:0] pc_base    = (instr_addr + `PC_AHEAD) & `PC_BIT1_CLEAR;
	wire [31:0] base_reg   = low_reg[rd];

	reg  [`MASK_W-1:0] start_mask;
	reg  [3:0]         start_cnt;
	reg  [31:0]        start_addr;
	integer            k;

	always @* begin
		start_mask = {`MASK_W{1'b0}};
		start_cnt  = 4'h0;
		start_addr = base_reg;
		if (is_sp_ldst) begin
			start_mask[rd] = 1'b1;
			start_addr     = stack_pointer_reg + word_off;
		end else if (is_pp) begin
			start_mask = {instr[`PP_EXTRA], instr[`LIST_W-1:0]};
			start_addr = stack_pointer_reg;
		end else if (is_multi) begin
			start_mask = {1'b0, instr[`LIST_W-1:0]};
		end
		for (k = 0; k < `MASK_W; k = k + 1) begin
			start_cnt = start_cnt + {3'h0, start_mask[k]};
		end
		// push starts at the lowest slot below the pointer
		if (is_pp && !lbit) begin
			start_addr = stack_pointer_reg - {26'h0, start_cnt, {`WORD_SHIFT{1'b0}}};
		end
	end

	// ---------------------------------------------------------------
	// transfer sequencing
	// ---------------------------------------------------------------
	wire [`MASK_W-1:0] cur_bit   = {{(`MASK_W-1){1'b0}}, 1'b1} << idx_reg;
	wire [`MASK_W-1:0] mask_left = mask_reg & ~cur_bit;
	wire [`MASK_W-1:0] find_in   = state_reg[0] ? start_mask : mask_left;
	wire [`IDX_W-1:0]  find_idx;
	wire               find_any;

	// lowest register first, so it lands at the lowest address
	lowest_set_finder #(.W (`MASK_W), .IW (`IDX_W)) u_finder (
		.mask (find_in),
		.idx  (find_idx),
		.any  (find_any));

	function [31:0] src_val;
		input [`IDX_W-1:0] i;
		src_val = (i == `EXTRA_IDX) ? link_register_reg : low_reg[i[2:0]];
	endfunction

	wire xfer_done = state_reg[1] && mem_req_reg && mem_ack;
	wire ld_low    = xfer_done && load_reg && (idx_reg != `EXTRA_IDX);
	wire ld_pc     = xfer_done && load_reg && (idx_reg == `EXTRA_IDX);
	wire multi_go  = take && (is_sp_ldst || is_pp || is_multi) && find_any;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg      <= S_IDLE;
			mask_reg       <= {`MASK_W{1'b0}};
			idx_reg        <= {`IDX_W{1'b0}};
			load_reg       <= 1'b0;
			wb_en_reg      <= 1'b0;
			wb_sp_reg      <= 1'b0;
			wb_idx_reg     <= 3'h0;
			wb_val_reg     <= `REG_RESET;
			pc_loaded_reg  <= 1'b0;
			refill_cnt_reg <= 2'h0;
			mem_req_reg    <= 1'b0;
			mem_write_reg  <= 1'b0;
			mem_addr_reg   <= `REG_RESET;
			mem_wdata_reg  <= `REG_RESET;
			ready_reg      <= 1'b0;
			done_reg       <= 1'b0;
			unsup_reg      <= 1'b0;
			branch_reg     <= 1'b0;
			target_reg     <= `REG_RESET;
		end else begin
			done_reg   <= 1'b0;
			unsup_reg  <= 1'b0;
			branch_reg <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				ready_reg <= 1'b1;
				if (take) begin
					if (multi_go) begin
						state_reg     <= S_MEM;
						ready_reg     <= 1'b0;
						mask_reg      <= start_mask;
						idx_reg       <= find_idx;
						load_reg      <= lbit;
						pc_loaded_reg <= 1'b0;
						mem_req_reg   <= 1'b1;
						mem_write_reg <= !lbit;
						mem_addr_reg  <= start_addr;
						mem_wdata_reg <= src_val(find_idx);
						wb_en_reg     <= !is_sp_ldst;
						wb_sp_reg     <= is_pp;
						wb_idx_reg    <= rd;
						// full descending: push ends at start, pop ends past top
						if (is_pp && !lbit)
							wb_val_reg <= start_addr;
						else
							wb_val_reg <= start_addr +
								{26'h0, start_cnt, {`WORD_SHIFT{1'b0}}};
					end else if (is_pp || is_multi || is_sp_ldst || is_addr || is_adj) begin
						// single-cycle forms, and empty lists
						done_reg <= 1'b1;
					end else begin
						unsup_reg <= 1'b1;
					end
				end
			end
			S_MEM: begin
				if (xfer_done) begin
					mask_reg <= mask_left;
					if (ld_pc) begin
						pc_loaded_reg <= 1'b1;
						target_reg    <= mem_rdata & `PC_BIT0_CLEAR;
					end
					if (find_any) begin
						idx_reg       <= find_idx;
						mem_addr_reg  <= mem_addr_reg + `WORD_BYTES;
						mem_wdata_reg <= src_val(find_idx);
					end else begin
						mem_req_reg   <= 1'b0;
						mem_write_reg <= 1'b0;
						state_reg     <= S_FIN;
					end
				end
			end
			S_FIN: begin
				// closing internal cycle, as the full-width form spends
				if (pc_loaded_reg) begin
					state_reg      <= S_REFILL;
					refill_cnt_reg <= `REFILL_CYCLES;
				end else begin
					state_reg <= S_IDLE;
					done_reg  <= 1'b1;
				end
			end
			S_REFILL: begin
				refill_cnt_reg <= refill_cnt_reg - 2'h1;
				if (refill_cnt_reg == 2'h1) begin
					state_reg  <= S_IDLE;
					done_reg   <= 1'b1;
					branch_reg <= 1'b1;
				end
			end
			default: begin
				state_reg   <= S_IDLE;
				mem_req_reg <= 1'b0;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	wire fin_wb = state_reg[2] && wb_en_reg;
	integer j;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (j = 0; j < `LIST_W; j = j + 1) begin
				low_reg[j] <= `REG_RESET;
			end
			stack_pointer_reg <= `REG_RESET;
			link_register_reg <= `REG_RESET;
		end else begin
			if (take && is_addr) begin
				if (lbit)
					low_reg[rd] <= stack_pointer_reg + word_off;
				else
					low_reg[rd] <= pc_base + word_off;
			end
			if (take && is_adj) begin
				if (instr[`ADJ_SIGN])
					stack_pointer_reg <= stack_pointer_reg - adj_mag;
				else
					stack_pointer_reg <= stack_pointer_reg + adj_mag;
			end
			// closing write-back comes after the loads, so it wins over a loaded base
			if (fin_wb && wb_sp_reg)
				stack_pointer_reg <= wb_val_reg;
			if (fin_wb && !wb_sp_reg)
				low_reg[wb_idx_reg] <= wb_val_reg;
			if (ld_low)
				low_reg[idx_reg[2:0]] <= mem_rdata;
		end
	end

	// ---------------------------------------------------------------
	// condition flags: only the other formats write them
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_flags_register_reg <= `FLAGS_RESET;
		end else if (flags_wr) begin
			status_flags_register_reg <= flags_wdata;
		end
	end

	// ---------------------------------------------------------------
	// register view
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dbg_reg <= `REG_RESET;
		end else begin
			case (dbg_sel)
			`DBG_SP:    dbg_reg <= stack_pointer_reg;
			`DBG_LR:    dbg_reg <= link_register_reg;
			`DBG_FLAGS: dbg_reg <= {28'h0, status_flags_register_reg};
			default:    dbg_reg <= (dbg_sel < `EXTRA_IDX) ? low_reg[dbg_sel[2:0]] : `REG_RESET;
			endcase
		end
	end

	assign instr_ready       = ready_reg;
	assign instr_done        = done_reg;
	assign instr_unsupported = unsup_reg;
	assign branch_valid      = branch_reg;
	assign branch_target     = target_reg;
	assign flags             = status_flags_register_reg;
	assign mem_req           = mem_req_reg;
	assign mem_write         = mem_write_reg;
	assign mem_addr          = mem_addr_reg;
	assign mem_wdata         = mem_wdata_reg;
	assign dbg_data          = dbg_reg;

endmodule // compact_stack_multi_ldst_decode

`default_nettype wire

// file: data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// word memory with programmable wait
// ----------------------------------------
module data_mem_model (
	// clock and reset
	input wire logic         mclk,
	input wire logic         reset_n,
	// data bus
	input wire logic         mem_req,
	input wire logic         mem_write,
	input wire logic [31:0]  mem_addr,
	input wire logic [31:0]  mem_wdata,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [31:0] mem [0:255];
	logic [31:0] last;
	int          wait_cycles = 0;
	int          cnt;
	assign mem_ack = mem_req && (cnt >= wait_cycles);
	// idle bus shows the inverse of the last word
	assign mem_rdata = mem_ack ? mem[mem_addr[9:2]] : ~last;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			last <= 32'h0;
		end else if (mem_ack) begin
			cnt <= 0;
			last <= mem_write ? mem_wdata : mem[mem_addr[9:2]];
			if (mem_write) mem[mem_addr[9:2]] <= mem_wdata;
		end else if (mem_req) begin
			cnt <= cnt + 1;
		end
	end
endmodule // data_mem_model
`default_nettype wire

// file: lowest_set_finder.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// lowest set bit of a mask, as an index
// ---------------------------------------------------------------
module lowest_set_finder #(
	parameter W  = 9,
	parameter IW = 4
) (
	// mask in
	input  wire [W-1:0]  mask,
	// result
	output reg  [IW-1:0] idx,
	output reg           any
);

	integer i;

	always @* begin
		idx = {IW{1'b0}};
		any = 1'b0;
		for (i = W - 1; i >= 0; i = i - 1) begin
			if (mask[i]) begin
				idx = i[IW-1:0];
				any = 1'b1;
			end
		end
	end

endmodule // lowest_set_finder

`default_nettype wire

// file: stack_ldst_map.vh
`ifndef STACK_LDST_MAP_VH
`define STACK_LDST_MAP_VH

// ---------------------------------------------------------------
// opcode fields of the compact 16-bit instruction
// ---------------------------------------------------------------
`define OP4_HI          15
`define OP4_LO          12
`define OP8_LO          8
`define LBIT            11
`define RD_HI           10
`define RD_LO           8
`define IMM8_HI         7
`define IMM8_LO         0
`define ADJ_SIGN        7
`define ADJ_HI          6
`define ADJ_LO          0
`define PP_SEL_HI       10
`define PP_SEL_LO       9
`define PP_EXTRA        8

`define OP_SP_LDST      4'h9
`define OP_ADDR_GEN     4'ha
`define OP_PUSH_POP     4'hb
`define OP_MULTI        4'hc
`define OP_SP_ADJ       8'hb0
`define PP_SEL_CODE     2'h2

// ---------------------------------------------------------------
// widths, shifts and constants
// ---------------------------------------------------------------
`define LIST_W          8
`define MASK_W          9
`define IDX_W           4
`define EXTRA_IDX       4'h8
`define WORD_SHIFT      2
`define WORD_BYTES      32'h0000_0004
`define PC_AHEAD        32'h0000_0004
`define PC_BIT1_CLEAR   32'hffff_fffd
`define PC_BIT0_CLEAR   32'hffff_fffe
`define REG_RESET       32'h0000_0000
`define FLAGS_RESET     4'h0
`define REFILL_CYCLES   2'h2
`define DBG_SP          4'h8
`define DBG_LR          4'h9
`define DBG_FLAGS       4'ha

`endif

// file: stack_ldst_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus, flag and completion checks
// ----------------------------------------
module stack_ldst_props (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// instruction side
	input wire logic        instr_ready,
	input wire logic        instr_done,
	input wire logic        instr_unsupported,
	input wire logic        branch_valid,
	input wire logic [31:0] branch_target,
	// flags
	input wire logic        flags_wr,
	input wire logic [3:0]  flags_wdata,
	input wire logic [3:0]  flags,
	// data bus
	input wire logic        mem_req,
	input wire logic        mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_ack
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_req_held: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata)
		&& $stable(mem_write)) else $error("bus request changed before ack");
	chk_word_align: assert property (
		mem_req |-> mem_addr[1:0] == 2'h0) else $error("bus address not word aligned");
	chk_addr_step: assert property (
		(mem_req && mem_ack) ##1 mem_req |-> mem_addr == $past(mem_addr) + 32'h4)
		else $error("transfer address not ascending by four");
	chk_flags_hold: assert property (
		!flags_wr |=> $stable(flags)) else $error("flags changed without a write");
	chk_flags_load: assert property (
		flags_wr |=> flags == $past(flags_wdata)) else $error("flag write lost");
	chk_branch_done: assert property (
		branch_valid |-> instr_done && !branch_target[0] && !mem_req)
		else $error("branch pulse malformed");
	chk_busy_xfer: assert property (
		mem_req |-> !instr_ready) else $error("ready while transferring");
	chk_ready_back: assert property (
		instr_done |=> instr_ready) else $error("ready not back after done");
	cover property (branch_valid);
	cover property (mem_req && mem_write && mem_ack);
	cover property (mem_req && !mem_ack);
	cover property (instr_unsupported);
endmodule // stack_ldst_props

bind compact_stack_multi_ldst_decode stack_ldst_props i_props (.mclk, .reset_n, .instr_ready,
	.instr_done, .instr_unsupported, .branch_valid, .branch_target, .flags_wr, .flags_wdata,
	.flags, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack);
`default_nettype wire

// file: tb_compact_stack_multi_ldst_decode.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_compact_stack_multi_ldst_decode;
	logic mclk = 0, reset_n = 0, instr_valid = 0, flags_wr = 0;
	logic instr_ready, instr_done, instr_unsupported, branch_valid, mem_req, mem_write, mem_ack;
	logic [15:0] instr = 16'h0;
	logic [31:0] instr_addr = 32'h0, branch_target, mem_addr, mem_wdata, mem_rdata, dbg_data;
	logic [31:0] v, br_tgt;
	logic [3:0]  flags_wdata = 4'h0, dbg_sel = 4'h0, flags;
	logic        br_seen, unsup_seen;
	int          miscompares = 0, checks_done = 0, cyc, c1;
	always #2 mclk = ~mclk;
	compact_stack_multi_ldst_decode i_dut (.mclk, .reset_n, .instr_valid, .instr, .instr_addr,
		.instr_ready, .instr_done, .instr_unsupported, .branch_valid, .branch_target, .flags_wr,
		.flags_wdata, .flags, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.dbg_sel, .dbg_data);
	data_mem_model i_mem (.mclk, .reset_n, .mem_req, .mem_write, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata);
	// ----------------------------------------
	// issue, readback and closing
	// ----------------------------------------
	task run(input logic [15:0] w);
		int n;
		@(negedge mclk) instr = w;
		instr_valid = 1'b1;
		n = 0;
		while (instr_ready !== 1'b1 && n < 100) begin
			@(negedge mclk) n++;
		end
		@(negedge mclk) instr_valid = 1'b0;
		cyc = 1;
		while (instr_done !== 1'b1 && instr_unsupported !== 1'b1 && cyc < 200) begin
			@(negedge mclk) cyc++;
		end
		unsup_seen = instr_unsupported;
		br_seen = branch_valid;
		br_tgt = branch_target;
	endtask
	task rd(input logic [3:0] s, input logic [31:0] e);
		@(negedge mclk) dbg_sel = s;
		@(negedge mclk) v = dbg_data;
		`CHK(v, e)
	endtask
	task test_done;
		$display("mismatches %0d of %0d comparisons", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_alu;
		@(negedge mclk) flags_wr = 1'b1;
		flags_wdata = 4'ha;
		@(negedge mclk) flags_wr = 1'b0;
		run(16'hb07f); rd(4'h8, 32'd508);
		run(16'hb09a); rd(4'h8, 32'd404);
		run(16'ha905); rd(4'h1, 32'd424);
		instr_addr = 32'h1002;
		run(16'ha203); rd(4'h2, 32'h1010);
		`CHK(flags, 4'ha)
	endtask
	task t_sp_mem;
		i_mem.mem[104] = 32'hffff_ffff;
		i_mem.mem[105] = 32'h1234_5678;
		run(16'h9103); `CHK(i_mem.mem[104], 32'd424)
		run(16'h9b04); rd(4'h3, 32'h1234_5678);
	endtask
	task t_stack;
		for (int i = 97; i < 101; i++) i_mem.mem[i] = 32'hffff_ffff;
		run(16'hb506); c1 = cyc;
		`CHK(i_mem.mem[98], 32'd424)
		`CHK(i_mem.mem[99], 32'h1010)
		`CHK(i_mem.mem[100], 32'h0)
		rd(4'h8, 32'd392);
		run(16'hb402); `CHK(c1 - cyc, 2)
		`CHK(i_mem.mem[97], 32'd424)
		run(16'hbc10); rd(4'h4, 32'd424);
		i_mem.mem[98] = 32'ha1;
		i_mem.mem[99] = 32'hb2;
		i_mem.mem[100] = 32'h2001;
		i_mem.wait_cycles = 2;
		run(16'hbd30); `CHK(br_seen, 1'b1)
		`CHK(br_tgt, 32'h2000)
		rd(4'h4, 32'ha1);
		rd(4'h5, 32'hb2);
		rd(4'h8, 32'd404);
	endtask
	task t_multi;
		i_mem.mem[106] = 32'hffff_ffff;
		i_mem.mem[107] = 32'hffff_ffff;
		i_mem.mem[108] = 32'h6666_0001;
		i_mem.mem[109] = 32'h7777_0002;
		i_mem.wait_cycles = 1;
		run(16'hc105); `CHK(i_mem.mem[106], 32'h0)
		`CHK(i_mem.mem[107], 32'h1010)
		rd(4'h1, 32'd432);
		run(16'hc9c0); rd(4'h6, 32'h6666_0001);
		rd(4'h7, 32'h7777_0002);
		rd(4'h1, 32'd440);
		i_mem.wait_cycles = 0;
	endtask
	task t_bad;
		run(16'h0000); `CHK(unsup_seen, 1'b1)
		run(16'hc100); `CHK(cyc, 1)
		`CHK(unsup_seen, 1'b0)
		rd(4'h1, 32'd440);
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		t_alu;
		t_sp_mem;
		t_stack;
		t_multi;
		t_bad;
		test_done;
	end
	initial begin
		#20000;
		miscompares++;
		test_done;
	end
endmodule // tb_compact_stack_multi_ldst_decode
`default_nettype wire
